// ---- hw/pxc_map.svh ----
// Offsets, field positions, reset values and widths for the block
`ifndef PXC_MAP_SVH
`define PXC_MAP_SVH

// Register address in the vendor management space
`define PXC_EXT_CTRL_ADDR 16'h8002

// Field positions
`define PXC_PREC_BIT 15
`define PXC_MII_SUPP_BIT 11
`define PXC_COORD_OVR_BIT 1
`define PXC_COORD_ROLE_BIT 0

// Reset values of the fields
`define PXC_PREC_RST 1'h0
`define PXC_MII_SUPP_RST 1'h1
`define PXC_COORD_OVR_RST 1'h0
`define PXC_COORD_ROLE_RST 1'h0

// Widths
`define PXC_DATA_W 16
`define PXC_ID_W 8

`endif

// ---- hw/pxc_pkg.sv ----
// Types shared by the extension control block
package pxc_pkg;

  // Software-visible control fields of the extension register
  typedef struct packed {
    logic prec_en;
    logic mii_supp;
    logic coord_ovr;
    logic coord_role;
  } pxc_ctrl_t;

  // PLCA indications travelling between the internal RS and the MII
  typedef struct packed {
    logic beacon;
    logic commit;
  } pxc_ind_t;

endpackage : pxc_pkg

// ---- hw/pxc_ext_ctrl.sv ----
// PLCA extension control: register, precedence, MII gating, role select
`timescale 1ns/10ps
`include "pxc_map.svh"
// Notes on behaviour
// - Bit 15 enables precedence mode, resets zero
// - Precedence mode ends cycle after each packet
// - Lowest node ID always wins under precedence
// - Bit 11 suppresses MII extensions while internal PLCA is off, resets one
// - Bit 1 override: role follows select bit
// - Without override, coordinator exactly when ID zero
// - Bit 0 selects coordinator, resets zero
// - Override ignores node ID for role
module pxc_ext_ctrl
  import pxc_pkg::*;
(
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // Management register access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [`PXC_DATA_W-1:0] reg_wdata,
  output logic [`PXC_DATA_W-1:0] reg_rdata,
  output logic reg_hit,
  // PLCA configuration and status from the RS
  input wire logic plca_en,
  input wire logic [`PXC_ID_W-1:0] local_id,
  input wire logic [`PXC_ID_W-1:0] cur_to_id,
  input wire logic pkt_done,
  // Role and arbitration results to the RS
  output logic coordinator,
  output logic cycle_restart,
  output logic prec_grant,
  // Indications between internal RS and the MII
  input wire pxc_ind_t rs_ind,
  input wire pxc_ind_t mii_ind,
  output pxc_ind_t to_mii,
  output pxc_ind_t to_rs
);

  // Stored fields, one flop each, gathered into the carrier struct
  logic prec_r;
  logic supp_r;
  logic ovr_r;
  logic role_r;
  pxc_ctrl_t ctrl;

  // Decode and access strobes
  logic addr_ok;
  logic wr_stb;
  logic rd_stb;
  logic any_stb;

  // Next values of the registered outputs, with the pass and own-ID terms they use
  logic [`PXC_DATA_W-1:0] rdata_nxt;
  logic role_nxt;
  logic restart_nxt;
  logic grant_nxt;
  logic ind_pass;
  logic at_own_id;
  pxc_ind_t to_mii_nxt;
  pxc_ind_t to_rs_nxt;

  // Address decode; every other offset is refused with no side effect
  always_comb begin
    if (reg_addr == `PXC_EXT_CTRL_ADDR) begin
      addr_ok = 1'b1;
    end else begin
      addr_ok = 1'b0;
    end
  end

  // Strobes are gated by the enable so a frozen block takes no access
  assign wr_stb = ce && reg_wr && addr_ok;
  assign rd_stb = ce && reg_rd && addr_ok;
  assign any_stb = wr_stb || rd_stb;

  // Precedence enable; off after reset so standard arbitration runs
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prec_r <= `PXC_PREC_RST;
    end else if (wr_stb) begin
      prec_r <= reg_wdata[`PXC_PREC_BIT];
    end
  end

  // Extension suppress; set after reset so a plain MAC sees no commands while internal PLCA is off
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      supp_r <= `PXC_MII_SUPP_RST;
    end else if (wr_stb) begin
      supp_r <= reg_wdata[`PXC_MII_SUPP_BIT];
    end
  end

  // Coordinator override; clear after reset so the node ID decides
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ovr_r <= `PXC_COORD_OVR_RST;
    end else if (wr_stb) begin
      ovr_r <= reg_wdata[`PXC_COORD_OVR_BIT];
    end
  end

  // Role select; only consulted while the override is set
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      role_r <= `PXC_COORD_ROLE_RST;
    end else if (wr_stb) begin
      role_r <= reg_wdata[`PXC_COORD_ROLE_BIT];
    end
  end

  // Fields in one carrier for the logic below
  assign ctrl.prec_en = prec_r;
  assign ctrl.mii_supp = supp_r;
  assign ctrl.coord_ovr = ovr_r;
  assign ctrl.coord_role = role_r;

  // Read word; unused bits are tied low, so writes to them are lost
  always_comb begin
    rdata_nxt = '0;
    if (rd_stb) begin
      rdata_nxt[`PXC_PREC_BIT] = ctrl.prec_en;
      rdata_nxt[`PXC_MII_SUPP_BIT] = ctrl.mii_supp;
      rdata_nxt[`PXC_COORD_OVR_BIT] = ctrl.coord_ovr;
      rdata_nxt[`PXC_COORD_ROLE_BIT] = ctrl.coord_role;
    end
  end

  // Read data stands one cycle and then returns to zero
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (ce) begin
      reg_rdata <= rdata_nxt;
    end
  end

  // Hit flags any access to the mapped offset, write or read
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_hit <= 1'b0;
    end else if (ce) begin
      reg_hit <= any_stb;
    end
  end

  // Role: override takes the select bit, else node ID zero decides
  always_comb begin
    if (ctrl.coord_ovr) begin
      role_nxt = ctrl.coord_role;
    end else begin
      role_nxt = (local_id == 8'h00);
    end
  end

  // Role is registered, so the RS sees a field write one cycle after the field takes it
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      coordinator <= 1'b0;
    end else if (ce) begin
      coordinator <= role_nxt;
    end
  end

  // Precedence ends the cycle after every packet sent or received; the
  // restart pulse sends the RS back to the lowest node ID. Peers on
  // standard PLCA will not follow it, so mixed segments misbehave.
  always_comb begin
    restart_nxt = 1'b0;
    if (ctrl.prec_en && plca_en) begin
      restart_nxt = pkt_done;
    end
  end

  // Restart stands one cycle for each packet end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cycle_restart <= 1'b0;
    end else if (ce) begin
      cycle_restart <= restart_nxt;
    end
  end

  // Opportunity has reached our own node ID
  assign at_own_id = (cur_to_id == local_id);

  // Every cycle restarts from zero, so a busy low ID keeps winning and
  // higher IDs may starve; that is the price of strict precedence
  always_comb begin
    grant_nxt = 1'b0;
    if (ctrl.prec_en && plca_en && !pkt_done) begin
      grant_nxt = at_own_id;
    end
  end

  // Grant is withheld in the cycle of a packet end, as a restart follows
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prec_grant <= 1'b0;
    end else if (ce) begin
      prec_grant <= grant_nxt;
    end
  end

  // Indications pass while internal PLCA runs or suppression is off
  assign ind_pass = plca_en || !ctrl.mii_supp;

  // Towards the MII: a plain MAC must not see commands it cannot decode
  always_comb begin
    to_mii_nxt = '0;
    if (ind_pass) begin
      to_mii_nxt = rs_ind;
    end
  end

  // From the MII: stray codes from a plain MAC must not reach the RS
  always_comb begin
    to_rs_nxt = '0;
    if (ind_pass) begin
      to_rs_nxt = mii_ind;
    end
  end

  // Indication towards the MII, one cycle behind the RS
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      to_mii <= '0;
    end else if (ce) begin
      to_mii <= to_mii_nxt;
    end
  end

  // Indication towards the RS, one cycle behind the MII
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      to_rs <= '0;
    end else if (ce) begin
      to_rs <= to_rs_nxt;
    end
  end

endmodule : pxc_ext_ctrl

// ---- verification/pxc_asserts.sv ----
// Assertion checker for the PLCA extension control block
`timescale 1ns/10ps
module pxc_asserts import pxc_pkg::*; (
  // Watched ports of the block
  input wire logic mclk, rst_n, ce, reg_wr, reg_rd, reg_hit, plca_en,
  input wire logic pkt_done, coordinator, cycle_restart, prec_grant,
  input wire logic [15:0] reg_addr, reg_wdata, reg_rdata,
  input wire logic [7:0] local_id, cur_to_id,
  input wire pxc_ind_t rs_ind, mii_ind, to_mii, to_rs);
  logic [3:0] f_r; // Prec, supp, ovr, role
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Shadow of the stored fields, so role and gating can be predicted
  always_ff @(posedge mclk) begin
    if (!rst_n) f_r <= 4'h4;
    else if (ce && reg_wr && reg_addr == 16'h8002)
      f_r <= {reg_wdata[15], reg_wdata[11], reg_wdata[1:0]};
  end
  // Causes seen one cycle before the outputs
  wire hit = (reg_wr || reg_rd) && reg_addr == 16'h8002;
  wire [15:0] rv = {f_r[3], 3'h0, f_r[2], 9'h000, f_r[1:0]};
  wire co = f_r[1] ? f_r[0] : local_id == 8'h00;
  wire gate = f_r[2] && !plca_en;
  wire [3:0] ind = {rs_ind, mii_ind};
  property p_hit; ce |=> reg_hit == $past(hit); endproperty
  a_hit: assert property (p_hit) else $error("hit wrong");
  property p_rd; ce && reg_rd && !reg_wr && hit |=> reg_rdata == $past(rv);
  endproperty
  a_rd: assert property (p_rd) else $error("read wrong");
  property p_un; (reg_rdata & 16'h77FC) == 16'h0000; endproperty
  a_un: assert property (p_un) else $error("unused set");
  property p_co; ce |=> coordinator == $past(co); endproperty
  a_co: assert property (p_co) else $error("role wrong");
  property p_ov; ce && f_r[1] |=> coordinator == $past(f_r[0]); endproperty
  a_ov: assert property (p_ov) else $error("override wrong");
  property p_go; ce && f_r[3] && plca_en && pkt_done |=> cycle_restart;
  endproperty
  a_go: assert property (p_go) else $error("no restart");
  property p_gr; ce && !(f_r[3] && plca_en) |=> !prec_grant; endproperty
  a_gr: assert property (p_gr) else $error("grant wrong");
  property p_in; ce |=> {to_mii, to_rs} == ($past(gate) ? 4'h0 : $past(ind));
  endproperty
  a_in: assert property (p_in) else $error("gating wrong");
  property p_gp; ce && f_r[3] && plca_en && !pkt_done
    && cur_to_id == local_id |=> prec_grant; endproperty
  a_gp: assert property (p_gp) else $error("no grant");
  property p_fz; !ce |=> $stable({reg_hit, reg_rdata, coordinator,
    cycle_restart, prec_grant, to_mii, to_rs}); endproperty
  a_fz: assert property (p_fz) else $error("not frozen");
endmodule : pxc_asserts
bind pxc_ext_ctrl pxc_asserts u_chk (.mclk(mclk), .rst_n(rst_n),
  .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_hit(reg_hit),
  .plca_en(plca_en), .pkt_done(pkt_done), .coordinator(coordinator),
  .cycle_restart(cycle_restart), .prec_grant(prec_grant),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .local_id(local_id), .cur_to_id(cur_to_id), .rs_ind(rs_ind),
  .mii_ind(mii_ind), .to_mii(to_mii), .to_rs(to_rs));

// ---- verification/pxc_rs_model.sv ----
// Far-side RS model: opportunity counter, packet ends, MII indications
`timescale 1ns/10ps
module pxc_rs_model import pxc_pkg::*; (
  // Clock, restart in, stimulus out
  input wire logic mclk, cycle_restart,
  output logic [7:0] cur_to_id = 8'h00,
  output logic pkt_done = 1'h0,
  output pxc_ind_t mii_ind = 2'h0);
  // Every precedence node restarts from the lowest ID together
  always @(posedge mclk) begin
    cur_to_id <= cycle_restart ? 8'h00 : cur_to_id + 8'h01;
    pkt_done <= 3'($urandom) == 3'h0;
    mii_ind <= 2'($urandom);
  end
endmodule : pxc_rs_model

// ---- verification/tb.sv ----
// Self-checking bench for the extension control block
`timescale 1ns/10ps
module tb import pxc_pkg::*; ;
  logic mclk = 1'h0, rst_n = 1'h0, ce = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
  logic plca_en = 1'h0, reg_hit, coordinator, cycle_restart, prec_grant;
  logic pkt_done, e, g;
  logic [15:0] reg_addr = 16'h8002, reg_wdata = 16'h0000, reg_rdata, d;
  logic [7:0] local_id = 8'h00, cur_to_id;
  pxc_ind_t rs_ind = 2'h0, mii_ind, to_mii, to_rs;
  int fail_count = 0, cmp_count = 0, cyc = 0;
  pxc_ext_ctrl dut (.mclk(mclk), .rst_n(rst_n), .ce(ce),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .plca_en(plca_en), .local_id(local_id), .cur_to_id(cur_to_id),
    .pkt_done(pkt_done), .coordinator(coordinator),
    .cycle_restart(cycle_restart), .prec_grant(prec_grant),
    .rs_ind(rs_ind), .mii_ind(mii_ind), .to_mii(to_mii), .to_rs(to_rs));
  pxc_rs_model u_rs (.mclk(mclk), .cycle_restart(cycle_restart),
    .cur_to_id(cur_to_id), .pkt_done(pkt_done), .mii_ind(mii_ind));
  always #5 mclk = !mclk;
  // Hang guard
  always @(posedge mclk) if (++cyc == 1500) begin
    fail_count++;
    close_out;
  end
  // Readable bits of a written word
  function automatic logic [15:0] rb(input logic [15:0] v);
    return v & 16'h8803;
  endfunction : rb
  task automatic chk(input logic [16:0] g, x);
    cmp_count++;
    if (g !== x) begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, g, x);
    end
  endtask : chk
  // One register access, then compare hit and read data
  task automatic acc(input logic w, input logic [15:0] a, v,
                     input logic [16:0] x);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, v};
    @(posedge mclk);
    {reg_wr, reg_rd} <= 2'h0;
    #1 chk({reg_hit, reg_rdata}, x);
    @(posedge mclk);
  endtask : acc
  // Random traffic; restarts only with precedence, gating with suppress
  task automatic run(input logic s);
    repeat (200) begin
      @(posedge mclk);
      e = plca_en && pkt_done && !s;
      d = (s && !plca_en) ? 16'h0000 : {12'h000, rs_ind, mii_ind};
      g = !s && plca_en && !pkt_done && cur_to_id == local_id;
      {plca_en, rs_ind} <= 3'($urandom);
      #1 chk({cycle_restart, to_mii, to_rs}, {e, d[3:0]});
      chk(prec_grant, g);
    end
  endtask : run
  initial begin
    void'($urandom(32'h872E));
    repeat (16) @(posedge mclk);
    rst_n <= 1'h1;
    @(posedge mclk);
    acc(1'h0, 16'h8002, 16'h0000, 17'h10800);
    acc(1'h1, 16'h8002, 16'hFFFF, 17'h10000);
    acc(1'h0, 16'h8002, 16'h0000, {1'h1, rb(16'hFFFF)});
    acc(1'h0, 16'h8004, 16'h0000, 17'h00000);
    $display("register test done");
    repeat (8) begin
      d = 16'($urandom);
      local_id <= d[2] ? 8'h00 : 8'($urandom);
      acc(1'h1, 16'h8002, d, 17'h10000);
      acc(1'h0, 16'h8002, 16'h0000, {1'h1, rb(d)});
      #1 chk(coordinator, d[1] ? d[0] : local_id == 8'h00);
    end
    $display("role test done");
    local_id <= 8'h03;
    acc(1'h1, 16'h8002, 16'h8000, 17'h10000);
    run(1'h0);
    acc(1'h1, 16'h8002, 16'h0800, 17'h10000);
    run(1'h1);
    $display("traffic test done");
    // Enable low: the write must not land and outputs must hold
    ce <= 1'h0;
    acc(1'h1, 16'h8002, 16'h0003, 17'h00000);
    ce <= 1'h1;
    acc(1'h0, 16'h8002, 16'h0000, 17'h10800);
    $display("freeze test done");
    close_out;
  end
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
endmodule : tb
